// File: pci_power_mgmt_capability.sv
`timescale 1ns/100ps
// Function
// RULE1: structure sits at pointer value held at 34h; fields at fixed offsets.
// RULE2: identifier byte is read-only and always reads 01h.
// RULE3: each function has exactly one list entry with identifier 01h.
// RULE4: next pointer is read-only and reads 00h, ending the list.
// RULE5: capabilities word is 16 bits, all read-only.
// RULE6: bits 15 to 11 flag wake signalling from D0, D1, D2, D3hot, D3cold.
// RULE7: bits 15,14,12,9 set; bits 13,11,10 set only on high-speed function.
// RULE8: bit 10 reports D2 support, zero when unsupported.
// RULE9: bit 9 reports D1 support, zero when unsupported.
// RULE10: low byte reads 10000010 on every function.
// RULE11: version field 010b means interface release 1.1.
// RULE12: aux current field 010b means 100 mA.
// RULE13: clock flag reads 0, wake needs no bus clock.
// RULE14: initialisation flag reads 0, no special init needed.
// RULE15: writes to identifier, pointer or capabilities word are ignored.
module pci_power_mgmt_capability (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // configuration access request
    input  wire logic        cfgRead,
    input  wire logic        cfgWrite,
    input  wire logic [1:0]  cfgFunc,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWriteData,
    // configuration access answer
    output logic      [31:0] cfgReadData_q,
    output logic             cfgReadValid_q,
    output logic             cfgClaim_q,
    output logic             cfgWriteIgnored_q
);

    // ------------------------------------------------------------------
    // types and signals
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ANSWER
    } state_t;

    state_t           state_q;
    state_t           state_d;
    logic      [31:0] readData_d;
    logic             readValid_d;
    logic             claim_d;
    logic             writeIgnored_d;
    logic      [31:0] headerWord;
    pm_cap_pkg::dec_t decode;
    logic             funcOk;
    logic             accept;

    // ------------------------------------------------------------------
    // constant header and address decode
    // ------------------------------------------------------------------
    pm_cap_rom capRom (
        .funcSel    (cfgFunc),
        .headerWord (headerWord)
    );

    pm_addr_decode addrDecode (
        .cfgAddr (cfgAddr),
        .decode  (decode)
    );

    assign funcOk = pm_cap_pkg::isValidFunc(cfgFunc);
    // a read wins if both strobes come together; a write changes nothing anyway
    assign accept = cfgRead || cfgWrite;

    // ------------------------------------------------------------------
    // next-state and answer logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d        = ST_IDLE;
        readData_d     = 32'h0000_0000;
        readValid_d    = 1'b0;
        claim_d        = 1'b0;
        writeIgnored_d = 1'b0;
        case (state_q)
            ST_IDLE, ST_ANSWER: begin
                // back-to-back requests are served every cycle
                if (accept && funcOk) begin
                    state_d = ST_ANSWER;
                    if (cfgRead) begin
                        readValid_d = 1'b1;
                        case (decode)
                            pm_cap_pkg::DEC_PTR: begin
                                readData_d = {24'h00_0000, pm_cap_pkg::PM_BASE}; // RULE1
                                claim_d    = 1'b1;
                            end
                            pm_cap_pkg::DEC_HEADER: begin
                                readData_d = headerWord;                // RULE5 RULE10
                                claim_d    = 1'b1;
                            end
                            pm_cap_pkg::DEC_CSR: begin
                                // csr, bridge and data bytes: located, not modelled
                                readData_d = 32'h0000_0000;             // RULE3
                                claim_d    = 1'b1;
                            end
                            default: begin
                                readData_d = 32'h0000_0000;
                                claim_d    = 1'b0;
                            end
                        endcase
                    end else begin
                        // write data dropped; nothing here is writable
                        claim_d        = (decode != pm_cap_pkg::DEC_NONE);
                        writeIgnored_d = claim_d && (cfgByteEn != 4'h0) &&
                                         (cfgWriteData == cfgWriteData); // RULE15
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q           <= ST_IDLE;
            cfgReadData_q     <= 32'h0000_0000;
            cfgReadValid_q    <= 1'b0;
            cfgClaim_q        <= 1'b0;
            cfgWriteIgnored_q <= 1'b0;
        end else begin
            state_q           <= state_d;
            cfgReadData_q     <= readData_d;
            cfgReadValid_q    <= readValid_d;
            cfgClaim_q        <= claim_d;
            cfgWriteIgnored_q <= writeIgnored_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_PTR_LOC: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
        cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) &&
        cfgAddr[7:2] == pm_cap_pkg::CAP_PTR_ADDR[7:2]
        |=> cfgReadValid_q && cfgClaim_q && cfgReadData_q[7:0] == pm_cap_pkg::PM_BASE)
        else $error("capabilities pointer does not hold the structure base");

    AST_CAPABILITY_IDENTIFIER: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
        cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadValid_q && cfgReadData_q[7:0] == 8'h01)
        else $error("identifier byte is not 01h");

    AST_ONE_ENTRY: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
        cfgRead && cfgAddr[7:2] != pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[7:0] != 8'h01)
        else $error("identifier 01h seen outside the structure");

    AST_NEXT_PTR: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
        cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[15:8] == 8'h00)
        else $error("next pointer is not 00h");

    AST_PMC_FS: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
        cfgRead && (cfgFunc == pm_cap_pkg::FUNC_FS0 || cfgFunc == pm_cap_pkg::FUNC_FS1) &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[31:16] == pm_cap_pkg::PMC_FULL_SPEED)
        else $error("full-speed capabilities word wrong");

    AST_PMC_HS: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        cfgRead && cfgFunc == pm_cap_pkg::FUNC_HS &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[31:27] == 5'h1F && cfgReadData_q[26:25] == 2'h3)
        else $error("high-speed wake or state bits wrong");

    AST_LOW_BYTE: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
        cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[23:16] == 8'h82 && cfgReadData_q[24] == 1'b0)
        else $error("capabilities low byte is not 10000010");

    AST_FIELDS: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
        cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgReadData_q[24:22] == 3'h2 && cfgReadData_q[18:16] == 3'h2 &&
            !cfgReadData_q[19] && !cfgReadData_q[21])
        else $error("aux, version, clock or init field wrong");

    AST_WRITE_IGNORED: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
        cfgWrite && !cfgRead && pm_cap_pkg::isValidFunc(cfgFunc) && cfgByteEn != 4'h0 &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        ##1 cfgRead && cfgFunc == pm_cap_pkg::FUNC_FS0 &&
        cfgAddr[7:2] == pm_cap_pkg::PM_BASE[7:2]
        |=> cfgWriteIgnored_q == 1'b0 &&
            cfgReadData_q == {pm_cap_pkg::PMC_FULL_SPEED, 16'h0001})
        else $error("write changed the header");

    AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
        !cfgRead |=> !cfgReadValid_q)
        else $error("read answer without a read");

endmodule : pci_power_mgmt_capability

// File: pm_cap_pkg.sv
package pm_cap_pkg;

    // ------------------------------------------------------------------
    // configuration space locations
    // ------------------------------------------------------------------
    localparam logic [7:0] CAP_PTR_ADDR  = 8'h34;  // capabilities pointer byte
    localparam logic [7:0] PM_BASE       = 8'h40;  // start of the power structure
    localparam logic [7:0] OFF_ID        = 8'h00;
    localparam logic [7:0] OFF_NEXT      = 8'h01;
    localparam logic [7:0] OFF_PMC       = 8'h02;
    localparam logic [7:0] OFF_CSR       = 8'h04;
    localparam logic [7:0] OFF_BSE       = 8'h06;
    localparam logic [7:0] OFF_DATA      = 8'h07;

    // ------------------------------------------------------------------
    // fixed header values
    // ------------------------------------------------------------------
    localparam logic [7:0] CAPABILITY_IDENTIFIER_VAL    = 8'h01;
    localparam logic [7:0] NEXT_PTR_VAL  = 8'h00;

    // ------------------------------------------------------------------
    // capabilities word field positions
    // ------------------------------------------------------------------
    localparam int WAKE_D0_BIT     = 11;
    localparam int WAKE_D1_BIT     = 12;
    localparam int WAKE_D2_BIT     = 13;
    localparam int WAKE_D3HOT_BIT  = 14;
    localparam int WAKE_D3COLD_BIT = 15;
    localparam int STATE2_BIT      = 10;
    localparam int STATE1_BIT      = 9;
    localparam int AUX_LSB         = 6;
    localparam int INIT_BIT        = 5;
    localparam int RSVD_BIT        = 4;
    localparam int CLKFLAG_BIT     = 3;
    localparam int VER_LSB         = 0;

    // ------------------------------------------------------------------
    // capabilities word field values
    // ------------------------------------------------------------------
    localparam logic [2:0] AUX_CURRENT_VAL  = 3'h2;  // 100 mA
    localparam logic [2:0] AUX_SELF_POWERED = 3'h0;
    localparam logic [2:0] SPEC_VERSION_VAL = 3'h2;  // interface release 1.1
    localparam logic       INIT_NEEDED_VAL  = 1'h0;
    localparam logic       WAKE_CLOCK_VAL   = 1'h0;  // wake needs no bus clock

    // expected whole words; only PMC_FULL_SPEED is used by checks
    localparam logic [15:0] PMC_FULL_SPEED = 16'hD282;
    localparam logic [15:0] PMC_HIGH_SPEED = 16'hFE82;

    // ------------------------------------------------------------------
    // functions of the controller
    // ------------------------------------------------------------------
    localparam logic [1:0] FUNC_FS0 = 2'h0;
    localparam logic [1:0] FUNC_FS1 = 2'h1;
    localparam logic [1:0] FUNC_HS  = 2'h2;

    typedef enum logic [1:0] {
        DEC_NONE,
        DEC_PTR,
        DEC_HEADER,
        DEC_CSR
    } dec_t;

    // high-speed function gets the extra wake and D2 bits
    function automatic logic isHighSpeed(input logic [1:0] func);
        isHighSpeed = (func == FUNC_HS);
    endfunction : isHighSpeed

    // only three functions exist
    function automatic logic isValidFunc(input logic [1:0] func);
        isValidFunc = (func == FUNC_FS0) || (func == FUNC_FS1) || (func == FUNC_HS);
    endfunction : isValidFunc

    // dword match of a byte address against a byte location
    function automatic logic sameDword(input logic [7:0] a, input logic [7:0] b);
        sameDword = (a[7:2] == b[7:2]);
    endfunction : sameDword

endpackage : pm_cap_pkg

// File: pm_cap_rom.sv
`timescale 1ns/100ps
module pm_cap_rom (
    // function select
    input  wire logic [1:0]  funcSel,
    // header dword at the structure base
    output logic      [31:0] headerWord
);

    logic        hs;
    logic [15:0] pmcWord;

    // ------------------------------------------------------------------
    // constant capabilities word, only the speed class varies
    // ------------------------------------------------------------------
    always_comb begin
        hs      = pm_cap_pkg::isHighSpeed(funcSel);
        pmcWord = 16'h0000;
        pmcWord[pm_cap_pkg::WAKE_D3COLD_BIT] = 1'b1;            // RULE6
        pmcWord[pm_cap_pkg::WAKE_D3HOT_BIT]  = 1'b1;            // RULE7
        pmcWord[pm_cap_pkg::WAKE_D2_BIT]     = hs;              // RULE7
        pmcWord[pm_cap_pkg::WAKE_D1_BIT]     = 1'b1;
        pmcWord[pm_cap_pkg::WAKE_D0_BIT]     = hs;
        pmcWord[pm_cap_pkg::STATE2_BIT]      = hs;              // RULE8
        pmcWord[pm_cap_pkg::STATE1_BIT]      = 1'b1;            // RULE9
        pmcWord[pm_cap_pkg::AUX_LSB +: 3]    = pm_cap_pkg::AUX_CURRENT_VAL;  // RULE12
        pmcWord[pm_cap_pkg::INIT_BIT]        = pm_cap_pkg::INIT_NEEDED_VAL;  // RULE14
        pmcWord[pm_cap_pkg::RSVD_BIT]        = 1'b0;            // RULE10
        pmcWord[pm_cap_pkg::CLKFLAG_BIT]     = pm_cap_pkg::WAKE_CLOCK_VAL;   // RULE13
        pmcWord[pm_cap_pkg::VER_LSB +: 3]    = pm_cap_pkg::SPEC_VERSION_VAL; // RULE11
        headerWord = {pmcWord, pm_cap_pkg::NEXT_PTR_VAL, pm_cap_pkg::CAPABILITY_IDENTIFIER_VAL}; // RULE2 RULE4
    end

endmodule : pm_cap_rom

// File: pm_addr_decode.sv
`timescale 1ns/100ps
module pm_addr_decode (
    // access address
    input  wire logic [7:0] cfgAddr,
    // which dword of ours is hit
    output pm_cap_pkg::dec_t decode
);

    // ------------------------------------------------------------------
    // dword decode; csr dword also holds bridge and data bytes
    // ------------------------------------------------------------------
    always_comb begin
        if (pm_cap_pkg::sameDword(cfgAddr, pm_cap_pkg::CAP_PTR_ADDR)) begin
            decode = pm_cap_pkg::DEC_PTR;
        end else if (pm_cap_pkg::sameDword(cfgAddr, 8'(pm_cap_pkg::PM_BASE +
                                                      pm_cap_pkg::OFF_ID))) begin
            decode = pm_cap_pkg::DEC_HEADER;                    // RULE1
        end else if (pm_cap_pkg::sameDword(cfgAddr, 8'(pm_cap_pkg::PM_BASE +
                                                      pm_cap_pkg::OFF_CSR))) begin
            decode = pm_cap_pkg::DEC_CSR;                       // RULE1
        end else begin
            decode = pm_cap_pkg::DEC_NONE;
        end
    end

endmodule : pm_addr_decode

// File: pci_host_model.sv
`timescale 1ns/100ps
module pci_host_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // configuration request
    output logic             cfgRead,
    output logic             cfgWrite,
    output logic      [1:0]  cfgFunc,
    output logic      [7:0]  cfgAddr,
    output logic      [3:0]  cfgByteEn,
    output logic      [31:0] cfgWriteData,
    // configuration answer
    input  wire logic [31:0] cfgReadData_q,
    input  wire logic        cfgReadValid_q,
    input  wire logic        cfgClaim_q,
    input  wire logic        cfgWriteIgnored_q
);
    // idle bus at time zero
    initial begin
        cfgRead      = 1'h0;
        cfgWrite     = 1'h0;
        cfgFunc      = 2'h0;
        cfgAddr      = 8'h00;
        cfgByteEn    = 4'h0;
        cfgWriteData = 32'h0000_0000;
    end

    // one transfer, held for hold cycles; released address and byte enables show the inverse
    // so a design that keeps reading stale values is caught
    task automatic access(input logic rd, input logic wr, input logic [1:0] fn,
                          input logic [7:0] adr, input logic [3:0] be, input int hold,
                          output logic [31:0] data, output logic [2:0] flags,
                          output int nValid, output logic [2:0] idleFlags);
        nValid = 0;
        @(posedge sys_clk);
        #1;
        cfgRead      = rd;
        cfgWrite     = wr;
        cfgFunc      = fn;
        cfgAddr      = adr;
        cfgByteEn    = be;
        cfgWriteData = 32'hFFFF_FFFF;
        repeat (hold) begin
            @(posedge sys_clk);
            #1;
            if (cfgReadValid_q === 1'h1) nValid++;
        end
        data  = cfgReadData_q;
        flags = {cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q};
        cfgRead      = 1'h0;
        cfgWrite     = 1'h0;
        cfgAddr      = ~adr;
        cfgByteEn    = ~be;
        cfgWriteData = 32'h0000_0000;
        @(posedge sys_clk);
        #1;
        idleFlags = {cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q};
    endtask : access

    // a write straight followed by a read with the write strobe still up;
    // the read must win and the write must leave the header untouched
    task automatic writeThenRead(input logic [1:0] fn, input logic [7:0] adr,
                                 output logic [2:0] wrFlags, output logic [31:0] data,
                                 output logic [2:0] rdFlags);
        @(posedge sys_clk);
        #1;
        cfgRead      = 1'h0;
        cfgWrite     = 1'h1;
        cfgFunc      = fn;
        cfgAddr      = adr;
        cfgByteEn    = 4'hF;
        cfgWriteData = 32'hFFFF_FFFF;
        @(posedge sys_clk);
        #1;
        wrFlags = {cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q};
        cfgRead = 1'h1;
        @(posedge sys_clk);
        #1;
        data    = cfgReadData_q;
        rdFlags = {cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q};
        cfgRead      = 1'h0;
        cfgWrite     = 1'h0;
        cfgAddr      = ~adr;
        cfgByteEn    = 4'h0;
        cfgWriteData = 32'h0000_0000;
        @(posedge sys_clk);
        #1;
    endtask : writeThenRead
endmodule : pci_host_model

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk;
    logic        rst;
    logic        cfgRead, cfgWrite, cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q;
    logic [1:0]  cfgFunc;
    logic [7:0]  cfgAddr, ptr;
    logic [3:0]  cfgByteEn;
    logic [31:0] cfgWriteData, cfgReadData_q, rdData;
    logic [2:0]  flags, idleFlags;
    int          nValid, nErrors, totalChecks;

    // ---------------------------------------------------------------
    // clock, design and host
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    pci_power_mgmt_capability pci_power_mgmt_capability_i (
        .sys_clk(sys_clk), .rst(rst), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
        .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWriteData(cfgWriteData), .cfgReadData_q(cfgReadData_q),
        .cfgReadValid_q(cfgReadValid_q), .cfgClaim_q(cfgClaim_q),
        .cfgWriteIgnored_q(cfgWriteIgnored_q));

    pci_host_model pci_host_model_i (
        .sys_clk(sys_clk), .rst(rst), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
        .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWriteData(cfgWriteData), .cfgReadData_q(cfgReadData_q),
        .cfgReadValid_q(cfgReadValid_q), .cfgClaim_q(cfgClaim_q),
        .cfgWriteIgnored_q(cfgWriteIgnored_q));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // capabilities word built bit by bit from the field meanings
    function automatic logic [15:0] capWord(input logic hs);
        capWord = {2'h3, hs, 1'h1, hs,
                   hs, 1'h1,
                   3'h2, 1'h0, 1'h0,
                   1'h0, 3'h2};
    endfunction : capWord

    task automatic req(input logic rd, input logic [1:0] fn, input logic [7:0] adr,
                       input logic [3:0] be, input int hold);
        pci_host_model_i.access(rd, !rd, fn, adr, be, hold, rdData, flags, nValid, idleFlags);
        check({29'h0, idleFlags}, 32'h0, "outputs after one cycle");
    endtask : req

    task automatic wrap_up();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // follow the list from the pointer byte on every function
    task automatic scenListWalk();
        for (int f = 0; f < 3; f++) begin
            req(1'h1, 2'(f), pm_cap_pkg::CAP_PTR_ADDR, 4'h0, 1);
            check({29'h0, flags}, 32'h6, "pointer read flags");
            ptr = rdData[7:0];
            check({24'h0, ptr}, {24'h0, pm_cap_pkg::PM_BASE}, "pointer");
            req(1'h1, 2'(f), ptr, 4'h0, 1);
            check({29'h0, flags}, 32'h6, "header flags");
            check({24'h0, rdData[7:0]}, 32'h01, "identifier");
            check({24'h0, rdData[15:8]}, 32'h00, "next pointer");
            check({16'h0, rdData[31:16]}, {16'h0, capWord(f == 2)}, "cap word");
        end
    endtask : scenListWalk

    // held read gives one answer per cycle
    task automatic scenBackToBack();
        req(1'h1, 2'h2, pm_cap_pkg::PM_BASE + 8'h02, 4'h0, 3);
        check(32'(nValid), 32'h3, "answers to held read");
        check(rdData, {capWord(1'h1), 16'h0001}, "held read data");
    endtask : scenBackToBack

    // control/status dword is claimed at base plus 4
    task automatic scenSecondDword();
        req(1'h1, 2'h0, pm_cap_pkg::PM_BASE + 8'h04, 4'h0, 1);
        check({29'h0, flags}, 32'h6, "base plus 4 flags");
        check(rdData, 32'h0, "base plus 4 data");
    endtask : scenSecondDword

    // writes are dropped and the header reads back the same
    task automatic scenWrites();
        for (int f = 0; f < 3; f++) begin
            req(1'h0, 2'(f), pm_cap_pkg::PM_BASE, 4'hF, 1);
            check({29'h0, flags}, 32'h3, "write flags");
            req(1'h0, 2'(f), pm_cap_pkg::PM_BASE + 8'h03, 4'h0, 1);
            check({29'h0, flags}, 32'h2, "empty write flags");
            req(1'h1, 2'(f), pm_cap_pkg::PM_BASE, 4'h0, 1);
            check(rdData, {capWord(f == 2), 16'h0001}, "read after write");
        end
    endtask : scenWrites

    // write straight into a read of the same dword; the read takes priority
    task automatic scenWriteRead();
        pci_host_model_i.writeThenRead(2'h0, pm_cap_pkg::PM_BASE, flags, rdData, idleFlags);
        check({29'h0, flags}, 32'h3, "write before read flags");
        check({29'h0, idleFlags}, 32'h6, "read over write flags");
        check(rdData, {capWord(1'h0), 16'h0001}, "read right after write");
    endtask : scenWriteRead

    // absent function and unmapped dword
    task automatic scenRefused();
        req(1'h1, 2'h3, pm_cap_pkg::PM_BASE, 4'h0, 1);
        check({29'h0, flags}, 32'h0, "absent function");
        req(1'h1, 2'h0, 8'h00, 4'h0, 1);
        check({29'h0, flags}, 32'h4, "unmapped flags");
        check(rdData, 32'h0, "unmapped data");
    endtask : scenRefused

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        nErrors     = 0;
        totalChecks = 0;
        rst         = 1'h1;
        repeat (16) @(posedge sys_clk);
        check({cfgReadData_q, cfgReadValid_q, cfgClaim_q, cfgWriteIgnored_q} == 35'h0,
              1, "outputs in reset");
        #1 rst = 1'h0;
        scenListWalk();
        scenBackToBack();
        scenSecondDword();
        scenWrites();
        scenWriteRead();
        scenRefused();
        wrap_up();
    end

    // a hang counts as a mismatch
    initial begin
        #200000;
        nErrors++;
        $display("Error at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule : tb_top
